// ### core/packed_decimal_integer_converter.sv
`timescale 1ns/1ps
module packed_decimal_integer_converter
    import bcd_pkg::*;
#(
    parameter int LOAD_CYC  = LOAD_STEPS,
    parameter int STORE_CYC = STORE_STEPS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Request
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [2:0]  req_op,
    input  wire logic [79:0] req_opnd,
    input  wire logic        invalid_mask,
    // Response
    output logic             rsp_valid,
    output logic [79:0]      rsp_data,
    output logic             rsp_digit_err,
    output logic             rsp_invalid,
    output logic             rsp_wr_mem,
    output logic             rsp_wr_fpr
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_FIN  = 2'b11
    } state_e;

    state_e      state_r;
    logic        is_load_r;
    logic        sign_r;
    logic        err_r;
    logic [5:0]  cnt_r;
    logic [59:0] acc_r;
    logic [71:0] digits_r;
    logic [71:0] bcd_r;
    logic [59:0] bin_r;
    logic        take;
    logic        simple_op;
    logic [79:0] simple_data;
    logic        simple_err;
    logic        load_err;
    logic [17:0] nib_bad;
    logic [14:0] exp_in;
    logic [14:0] e_unb;
    logic [63:0] shifted;
    logic        st_small;
    logic        st_big;
    logic        st_inv;
    logic [59:0] st_int;
    logic [5:0]  msb;
    logic [79:0] load_res;

    bcd_step_if stp ();

    bcd_step u_step (
        .stp (stp.unit)
    );

    function automatic logic digit_ok(input logic [3:0] d);
        return d <= DIGIT_MAX; // RULE1
    endfunction

    function automatic logic [5:0] msb_pos(input logic [59:0] v);
        logic [5:0] p;
        p = 6'h0;
        for (int i = 0; i < BIN_W; i++) begin
            if (v[i]) begin
                p = 6'(i);
            end
        end
        return p;
    endfunction

    assign req_ready = (state_r == ST_IDLE);
    assign take      = req_valid && req_ready;
    assign simple_op = (req_op == OP_UNP_ADD) || (req_op == OP_UNP_MUL) ||
                       (req_op == OP_PACK) || (req_op == OP_UNPACK);

    // ****************************************************************
    // Single-cycle digit operations
    // ****************************************************************
    always_comb begin
        simple_data = 80'h0;
        simple_err  = 1'b0;
        unique case (req_op)
            OP_UNP_ADD: begin
                simple_data = {76'h0, req_opnd[3:0]}; // RULE2 RULE3
                simple_err  = !digit_ok(req_opnd[3:0]);
            end
            OP_UNP_MUL: begin
                simple_data = {76'h0, req_opnd[3:0]}; // RULE2
                simple_err  = !digit_ok(req_opnd[3:0]) || (req_opnd[7:4] != 4'h0); // RULE3
            end
            OP_PACK: begin
                simple_data = {72'h0, req_opnd[11:8], req_opnd[3:0]}; // RULE4
                simple_err  = !digit_ok(req_opnd[11:8]) || !digit_ok(req_opnd[3:0]);
            end
            OP_UNPACK: begin
                simple_data = {64'h0, 4'h0, req_opnd[7:4], 4'h0, req_opnd[3:0]}; // RULE4
                simple_err  = !digit_ok(req_opnd[7:4]) || !digit_ok(req_opnd[3:0]);
            end
            default: begin
                simple_data = 80'h0;
                simple_err  = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Load digit check and store range check
    // ****************************************************************
    for (genvar g = 0; g < DEC_DIGITS; g++) begin : g_chk
        assign nib_bad[g] = !digit_ok(req_opnd[g*4 +: 4]); // RULE5
    end
    assign load_err = |nib_bad;

    // Fraction bits are truncated toward zero before conversion
    assign exp_in   = req_opnd[78:64];
    assign st_small = exp_in < FP_BIAS;
    assign e_unb    = exp_in - FP_BIAS; // RULE14
    assign st_big   = !st_small && (e_unb > STORE_MAXEXP);
    assign shifted  = req_opnd[63:0] >> (6'd63 - e_unb[5:0]);
    assign st_int   = (st_small || st_big) ? 60'h0 : shifted[59:0];
    assign st_inv   = (exp_in == EXP_ALL1) || st_big || (st_int > DEC_MAX); // RULE15 RULE9

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    assign stp.acc_in = acc_r;
    assign stp.digit  = digits_r[71:68]; // RULE6
    assign stp.bcd_in = bcd_r;
    assign stp.bit_in = bin_r[59];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            cnt_r   <= 6'h0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    cnt_r <= 6'h0;
                    if (take && ((req_op == OP_LOAD) || (req_op == OP_STORE && !st_inv))) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    cnt_r <= cnt_r + 6'h1;
                    if (cnt_r == (is_load_r ? 6'(LOAD_CYC - 1) : 6'(STORE_CYC - 1))) begin
                        state_r <= ST_FIN;
                    end
                end
                ST_FIN: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            is_load_r <= 1'b0;
            sign_r    <= 1'b0;
            err_r     <= 1'b0;
            acc_r     <= 60'h0;
            digits_r  <= 72'h0;
            bcd_r     <= 72'h0;
            bin_r     <= 60'h0;
        end else if (state_r == ST_IDLE && take) begin
            is_load_r <= (req_op == OP_LOAD);
            sign_r    <= req_opnd[SIGN_BIT]; // RULE7 RULE8
            err_r     <= load_err && (req_op == OP_LOAD);
            acc_r     <= 60'h0;
            digits_r  <= req_opnd[71:0];
            bcd_r     <= 72'h0;
            bin_r     <= st_int;
        end else if (state_r == ST_RUN) begin
            if (is_load_r) begin
                acc_r    <= stp.acc_out; // RULE11
                digits_r <= {digits_r[67:0], 4'h0};
            end else begin
                bcd_r <= stp.bcd_out;
                bin_r <= {bin_r[58:0], 1'b0};
            end
        end
    end

    // ****************************************************************
    // Normalisation into double-extended
    // ****************************************************************
    assign msb      = msb_pos(acc_r);
    // Zero keeps its sign: both zeros load as signed zero
    assign load_res = (acc_r == 60'h0) ? {sign_r, 79'h0} :
                      {sign_r, FP_BIAS + {9'h0, msb},
                       64'({4'h0, acc_r} << (6'd63 - msb))}; // RULE11 RULE14

    // ****************************************************************
    // Response
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rsp_valid     <= 1'b0;
            rsp_data      <= 80'h0;
            rsp_digit_err <= 1'b0;
            rsp_invalid   <= 1'b0;
            rsp_wr_mem    <= 1'b0;
            rsp_wr_fpr    <= 1'b0;
        end else begin
            rsp_valid     <= 1'b0;
            rsp_digit_err <= 1'b0;
            rsp_invalid   <= 1'b0;
            rsp_wr_mem    <= 1'b0;
            rsp_wr_fpr    <= 1'b0;
            if (state_r == ST_IDLE && take && simple_op) begin
                rsp_valid     <= 1'b1;
                rsp_data      <= simple_data;
                rsp_digit_err <= simple_err;
            end else if (state_r == ST_IDLE && take && req_op == OP_STORE && st_inv) begin
                rsp_valid   <= 1'b1;
                rsp_invalid <= 1'b1; // RULE15
                rsp_wr_mem  <= invalid_mask;
                rsp_data    <= invalid_mask ? DEC_INDEF : 80'h0; // RULE12
            end else if (state_r == ST_IDLE && take &&
                         !(req_op == OP_LOAD || req_op == OP_STORE)) begin
                rsp_valid     <= 1'b1;
                rsp_data      <= 80'h0;
                rsp_digit_err <= 1'b1;
            end else if (state_r == ST_FIN) begin
                rsp_valid <= 1'b1;
                // Decimal result only ever goes to memory, binary one to the register file
                rsp_wr_fpr    <= is_load_r; // RULE10
                rsp_wr_mem    <= !is_load_r; // RULE10
                rsp_digit_err <= err_r; // RULE13
                rsp_data      <= is_load_r ? load_res : {sign_r, 7'h0, bcd_r}; // RULE8
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_load_taken;
        take && req_op == OP_LOAD;
    endsequence

    sequence s_store_bad;
        take && req_op == OP_STORE && st_inv;
    endsequence

    AST_DIGIT_ERR: assert property (take && req_op == OP_UNP_ADD && req_opnd[3:0] > 4'h9 // RULE1
        |=> rsp_valid && rsp_digit_err) else $error("bad digit not flagged");
    AST_UNP_LOW: assert property (take && req_op == OP_UNP_ADD // RULE2
        |=> rsp_data == {76'h0, $past(req_opnd[3:0])} &&
            !rsp_digit_err == $past(req_opnd[3:0] <= 4'h9))
        else $error("unpacked digit wrong");
    AST_MUL_HIGH: assert property (take && req_op == OP_UNP_MUL && req_opnd[7:4] != 4'h0 // RULE3
        |=> rsp_digit_err) else $error("multiply high nibble not flagged");
    AST_PACK: assert property (take && req_op == OP_PACK // RULE4
        |=> rsp_data[7:0] == {$past(req_opnd[11:8]), $past(req_opnd[3:0])})
        else $error("pack order wrong");
    // Answer is sampled twenty edges after the take edge
    AST_LOAD_LAT: assert property (s_load_taken |=> !rsp_valid ##19 rsp_valid && rsp_wr_fpr) // RULE5
        else $error("load response late or early");
    AST_LOAD_SIGN: assert property (s_load_taken ##20 1'b1 // RULE7
        |-> rsp_data[79] == $past(req_opnd[79], 20)) else $error("load sign lost");
    AST_LOAD_NORM: assert property (state_r == ST_FIN && is_load_r && acc_r != 60'h0 // RULE14
        |=> rsp_data[63] && rsp_data[78:64] >= FP_BIAS && rsp_data[78:64] <= FP_BIAS + 15'd59)
        else $error("load not normalised");
    AST_LOAD_EXACT: assert property (state_r == ST_FIN && is_load_r && acc_r != 60'h0 // RULE11
        |=> (rsp_data[63:0] >> (6'd63 - 6'(rsp_data[78:64] - FP_BIAS))) == {4'h0, $past(acc_r)})
        else $error("load not exact");
    AST_INDEF: assert property ((s_store_bad and invalid_mask) // RULE12
        |=> rsp_wr_mem && rsp_data == 80'hFFFF_C000_0000_0000_0000)
        else $error("indefinite wrong");
    AST_STORE_INV: assert property (take && req_op == OP_STORE && req_opnd[78:64] == 15'h7FFF // RULE15
        |=> rsp_invalid && rsp_valid) else $error("NaN store not invalid");
    AST_STORE_RANGE: assert property (rsp_valid && rsp_wr_mem && !rsp_invalid // RULE9
        |-> rsp_data[78:72] == 7'h0 && rsp_data[71:68] <= 4'h9 && rsp_data[3:0] <= 4'h9)
        else $error("stored digits out of range");

endmodule

// ### core/bcd_pkg.sv
// Summary of operation
// RULE1: A decimal digit is four bits; only values zero to nine are valid.
// RULE2: Unpacked byte digit value comes only from bits zero to three.
// RULE3: Add/subtract ignore bits four to seven; multiply/divide need them zero.
// RULE4: Packed byte holds two digits; upper nibble is the more significant.
// RULE5: Eighty-bit decimal integer holds eighteen digits in its lowest nine bytes.
// RULE6: Least digit in low nibble of byte zero; most digit in top nibble.
// RULE7: Top bit is sign, one negative; other seven sign-byte bits ignored on input.
// RULE8: Negatives are sign-magnitude; digit field never two's complemented.
// RULE9: Range is plus or minus ten-to-eighteen minus one; both zeros accepted.
// RULE10: Decimal format lives only in memory, never in a floating-point register.
// RULE11: Decimal load converts exactly to double-extended format, with no rounding.
// RULE12: Masked invalid on decimal store writes the fixed indefinite pattern.
// RULE13: Loading the indefinite pattern gives an undefined result.
// RULE14: Double-extended exponent bias is sixteen thousand three hundred eighty-three.
// RULE15: Store flags invalid for NaN, infinity or out-of-range source.
package bcd_pkg;

    // ****************************************************************
    // Operations
    // ****************************************************************
    localparam int         OP_W       = 3;
    localparam logic [2:0] OP_UNP_ADD = 3'h0;
    localparam logic [2:0] OP_UNP_MUL = 3'h1;
    localparam logic [2:0] OP_PACK    = 3'h2;
    localparam logic [2:0] OP_UNPACK  = 3'h3;
    localparam logic [2:0] OP_LOAD    = 3'h4;
    localparam logic [2:0] OP_STORE   = 3'h5;

    // ****************************************************************
    // Formats
    // ****************************************************************
    localparam int          DEC_DIGITS   = 18;
    localparam int          DIGIT_W      = 4;
    localparam int          BCD_W        = 72;
    localparam int          BIN_W        = 60;
    localparam int          SIGN_BIT     = 79;
    localparam int          EXP_LSB      = 64;
    localparam logic [3:0]  DIGIT_MAX    = 4'h9;
    localparam logic [3:0]  DABBLE_LIM   = 4'h5;
    localparam logic [3:0]  DABBLE_ADD   = 4'h3;
    localparam logic [14:0] FP_BIAS      = 15'h3FFF;
    localparam logic [14:0] EXP_ALL1     = 15'h7FFF;
    localparam logic [14:0] STORE_MAXEXP = 15'h003B;
    localparam logic [59:0] DEC_MAX      = 60'hDE0_B6B3_A763_FFFF;
    localparam logic [79:0] DEC_INDEF    = 80'hFFFF_C000_0000_0000_0000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int LOAD_STEPS  = 18;
    localparam int STORE_STEPS = 60;

endpackage

// ### core/bcd_step_if.sv
`timescale 1ns/1ps
interface bcd_step_if;
    logic [59:0] acc_in;
    logic [3:0]  digit;
    logic [59:0] acc_out;
    logic [71:0] bcd_in;
    logic        bit_in;
    logic [71:0] bcd_out;

    modport ctl  (output acc_in, digit, bcd_in, bit_in, input acc_out, bcd_out);
    modport unit (input acc_in, digit, bcd_in, bit_in, output acc_out, bcd_out);
endinterface

// ### core/bcd_step.sv
`timescale 1ns/1ps
module bcd_step
    import bcd_pkg::*;
(
    // Step operands and results
    bcd_step_if.unit stp
);

    logic [71:0] adj;

    // Decimal accumulate, most significant digit first: acc*10 + digit
    assign stp.acc_out = (stp.acc_in << 3) + (stp.acc_in << 1) + {56'h0, stp.digit}; // RULE11

    // Shift-and-add-three: binary bit enters at the bottom
    for (genvar g = 0; g < DEC_DIGITS; g++) begin : g_dab
        assign adj[g*4 +: 4] = (stp.bcd_in[g*4 +: 4] >= DABBLE_LIM) ?
                               stp.bcd_in[g*4 +: 4] + DABBLE_ADD : stp.bcd_in[g*4 +: 4];
    end
    assign stp.bcd_out = {adj[70:0], stp.bit_in};

endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_top
    import bcd_pkg::*;
;
    // ************************************************************
    // Design hookup
    // ************************************************************
    logic        clk;
    logic        rst_b;
    logic        req_valid;
    logic        req_ready;
    logic [2:0]  req_op;
    logic [79:0] req_opnd;
    logic        invalid_mask;
    logic        rsp_valid;
    logic [79:0] rsp_data;
    logic        rsp_digit_err;
    logic        rsp_invalid;
    logic        rsp_wr_mem;
    logic        rsp_wr_fpr;
    int          bad_count;
    int          n_tests;
    int          cyc;
    int          r_n;
    logic [79:0] r_data;
    logic        r_err;
    logic        r_inv;
    logic        r_mem;
    logic        r_fpr;

    packed_decimal_integer_converter packed_decimal_integer_converter_i (
        .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .req_opnd(req_opnd), .invalid_mask(invalid_mask),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_digit_err(rsp_digit_err),
        .rsp_invalid(rsp_invalid), .rsp_wr_mem(rsp_wr_mem), .rsp_wr_fpr(rsp_wr_fpr));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Longest op is 62 cycles; 40 ops stay well below this ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            end_sim();
        end
    end

    // ************************************************************
    // Reference arithmetic
    // ************************************************************
    function automatic logic [63:0] bin_of(input logic [71:0] d);
        logic [63:0] v;
        v = 64'h0;
        for (int i = 17; i >= 0; i--) v = v * 10 + 64'(d[i*4 +: 4]);
        return v;
    endfunction

    function automatic logic [79:0] fp_of(input logic s, input logic [63:0] m);
        int p;
        p = -1;
        for (int i = 0; i < 64; i++) if (m[i]) p = i;
        if (p < 0) return {s, 79'h0};
        return {s, FP_BIAS + 15'(p), m << (63 - p)};
    endfunction

    // ************************************************************
    // Driver
    // ************************************************************
    task automatic run(input logic [2:0] op, input logic [79:0] opnd, input logic msk);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req_op = op;
        req_opnd = opnd;
        invalid_mask = msk;
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        // Count the edge at which the answer is sampled, the take edge being one
        n = 1;
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
            @(negedge clk);
        end
        r_n = n;
        r_data = rsp_data;
        r_err = rsp_digit_err;
        r_inv = rsp_invalid;
        r_mem = rsp_wr_mem;
        r_fpr = rsp_wr_fpr;
        @(negedge clk);
        `CHK(rsp_valid, 1'b0)
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_simple();
        logic [2:0] ops [10] = '{OP_UNP_ADD, OP_UNP_ADD, OP_UNP_MUL, OP_UNP_MUL, OP_PACK,
                                 OP_PACK, OP_UNPACK, OP_UNPACK, 3'h6, 3'h7};
        logic [15:0] arg [10] = '{16'h00F7, 16'h003A, 16'h0007, 16'h0017, 16'h0503,
                                 16'h050B, 16'h0092, 16'h00A2, 16'h0000, 16'h0000};
        logic       err [10] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 10; i++) begin
            run(ops[i], {64'h0, arg[i]}, 1'b0);
            `CHK(r_n, 1)
            `CHK(r_err, err[i])
        end
        run(OP_UNP_ADD, 80'h00F7, 1'b0);
        `CHK(r_data, 80'h7)
        run(OP_PACK, 80'h0503, 1'b0);
        `CHK(r_data[7:0], 8'h53)
        run(OP_UNPACK, 80'h0092, 1'b0);
        `CHK({r_data[11:8], r_data[3:0]}, 8'h92)
        run(3'h7, 80'h0092, 1'b0);
        `CHK(r_data, 80'h0)
    endtask

    task automatic t_back_to_back();
        @(negedge clk);
        req_valid = 1'b1;
        req_op = OP_PACK;
        req_opnd = 80'h0102;
        @(posedge clk);
        @(negedge clk);
        req_opnd = 80'h0304;
        `CHK(rsp_valid, 1'b1)
        `CHK(rsp_data[7:0], 8'h12)
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        `CHK(rsp_valid, 1'b1)
        `CHK(rsp_data[7:0], 8'h34)
    endtask

    task automatic t_load();
        logic [79:0] v [6] = '{{8'h00, 72'h1}, {8'h80, 72'h12}, {8'h7F, {18{4'h9}}},
                               {8'h80, 72'h0}, {8'h00, 72'h0},
                               {8'hFF, 72'h12_3456_7890_1234_5678}};
        for (int i = 0; i < 6; i++) begin
            run(OP_LOAD, v[i], 1'b0);
            `CHK(r_n, 20)
            `CHK(r_data, fp_of(v[i][79], bin_of(v[i][71:0])))
            `CHK({r_fpr, r_mem, r_err}, 3'h4)
        end
        run(OP_LOAD, {8'h00, {18{4'h9}}}, 1'b0);
        `CHK(r_data, {1'b0, 15'h403A, DEC_MAX, 4'h0})
        run(OP_LOAD, {8'h00, 72'h0A}, 1'b0);
        `CHK(r_err, 1'b1)
        // Indefinite pattern loads to an undefined value; only the flags are judged
        run(OP_LOAD, DEC_INDEF, 1'b0);
        `CHK(r_err, 1'b1)
        `CHK(r_fpr, 1'b1)
    endtask

    task automatic t_store();
        logic [79:0] v [6] = '{{8'h00, 72'h1}, {8'h80, 72'h12}, {8'h00, {18{4'h9}}},
                               {8'h80, 72'h0}, {8'h00, 72'h0},
                               {8'h80, 72'h12_3456_7890_1234_5678}};
        for (int i = 0; i < 6; i++) begin
            run(OP_STORE, fp_of(v[i][79], bin_of(v[i][71:0])), 1'b1);
            `CHK(r_n, 62)
            `CHK(r_data, v[i])
            `CHK({r_mem, r_inv, r_fpr}, 3'h4)
        end
        run(OP_STORE, {1'b0, 15'h3FFF, 64'hC000_0000_0000_0000}, 1'b0);
        `CHK(r_data, {8'h00, 72'h1})
    endtask

    task automatic t_store_invalid();
        logic [79:0] v [4] = '{{1'b0, 15'h7FFF, 64'h8000_0000_0000_0000},
                               {1'b1, 15'h7FFF, 64'hC000_0000_0000_0000},
                               fp_of(1'b0, {4'h0, DEC_MAX} + 64'h1),
                               {1'b1, 15'h403B, 64'h8000_0000_0000_0000}};
        for (int i = 0; i < 8; i++) begin
            run(OP_STORE, v[i/2], i[0]);
            `CHK(r_n, 1)
            `CHK({r_inv, r_mem}, {1'b1, i[0]})
            `CHK(r_data, i[0] ? DEC_INDEF : 80'h0)
        end
    endtask

    // ************************************************************
    // Sequence and verdict
    // ************************************************************
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req_op = OP_UNP_ADD;
        req_opnd = 80'h0;
        invalid_mask = 1'b0;
        repeat (10) @(negedge clk);
        `CHK({req_ready, rsp_valid, rsp_data}, {2'b10, 80'h0})
        rst_b = 1'b1;
        t_simple();
        t_back_to_back();
        t_load();
        t_store();
        t_store_invalid();
        end_sim();
    end
endmodule
